// >>> logic/svsi_pkg.sv
// Package of register map, field positions and reset values for the supply voltage sense interrupt block
`default_nettype none
package svsi_pkg;
    // Register byte offsets (one aligned word each)
    localparam logic [7:0] SVSI_OFF_ENABLE_CTRL = 8'h00;
    localparam logic [7:0] SVSI_OFF_STATUS      = 8'h04;
    localparam logic [7:0] SVSI_OFF_IRQ_ENABLE  = 8'h08;
    localparam logic [7:0] SVSI_OFF_IRQ_FLAGS   = 8'h0c;
    localparam logic [7:0] SVSI_OFF_RSVD_LO     = 8'h10;
    localparam logic [7:0] SVSI_OFF_RSVD_HI     = 8'h18;
    localparam logic [7:0] SVSI_OFF_MODE        = 8'h20;

    // Enable/control register fields
    localparam int SVSI_SESE_BIT = 0;
    localparam int SVSI_SEAE_BIT = 1;
    localparam int SVSI_SUSE_BIT = 2;
    localparam int SVSI_SUAE_BIT = 3;
    localparam int SVSI_VLS_LSB  = 4;
    localparam int SVSI_VHS_BIT  = 6;
    localparam logic [7:0] SVSI_CTRL_MASK = 8'h7f;

    // Status, enable and flag register fields
    localparam int SVSI_LOW_BIT  = 0;
    localparam int SVSI_HIGH_BIT = 1;

    // Mode register fields
    localparam int SVSI_SPECIAL_BIT = 0;
    localparam int SVSI_STOP_BIT    = 1;

    // Reset values
    localparam logic [7:0] SVSI_CTRL_RST  = 8'h00;
    localparam logic [1:0] SVSI_IE_RST    = 2'h0;
    localparam logic [1:0] SVSI_IF_RST    = 2'h0;
    localparam logic [7:0] SVSI_RSVD_RST  = 8'h00;
    localparam logic [1:0] SVSI_MODE_RST  = 2'h0;
endpackage
`default_nettype wire

// >>> logic/svsi_cond_sync.sv
// Two-flop synchroniser with change detect for one comparator condition
`timescale 1ns/100ps
`default_nettype none
module svsi_cond_sync
    import svsi_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Condition in and out
    input  wire logic cond_in,
    output logic      cond_sync,
    output logic      cond_changed
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Only sync_r looks at meta_r; the edge detect works on settled copies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= cond_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // One pulse for every settled change, either direction
    assign cond_sync    = sync_r;
    assign cond_changed = sync_r ^ prev_r;
endmodule
`default_nettype wire

// >>> logic/svsi_top.sv
// Supply voltage sense interrupt logic with APB register slave
// Operation
// - High flag requests interrupt only while high enable bit 1 is set.
// - Low flag requests interrupt only while low enable bit 0 is set.
// - High flag bit 1 sets on every high condition change.
// - Low flag bit 0 sets on every low condition change.
// - Flags clear only by writing one; zero writes leave them unchanged.
// - Interrupt enable register is read/write at any time.
// - Reserved test registers take writes only in special mode.
// - Request delivered only in run mode; stop mode leaves flags alone.
// - Both level enables clear forces both condition bits to zero.
// - Disabling during an active condition sets its flag once more.
// - Both gated sources merge into one module interrupt line.
// - Two-bit low threshold select picks one of four low thresholds.
// - High threshold select bit picks one of two high thresholds.
// - Setting sense-pin level enable clears the supply-pin level enable.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module svsi_top
    import svsi_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Analog comparator interface
    input  wire logic        low_cmp_in,
    input  wire logic        high_cmp_in,
    output logic             sense_pin_level_enable,
    output logic             supply_pin_level_enable,
    output logic             supply_adc_connect,
    output logic             sense_adc_connect,
    output logic [1:0]       low_threshold_select,
    output logic             high_threshold_select,
    // Interrupt
    output logic             module_irq
);
    // Register state
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [1:0]  irq_en_r;
    logic [1:0]  irq_flag_r;
    logic [1:0]  irq_flag_nxt;
    logic [7:0]  rsvd_r [2];
    logic [1:0]  mode_r;
    logic [31:0] prdata_r;

    // One address match per register, shared by the write enables and the read mux
    function automatic logic svsi_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    // Access decode; read data is fetched in the setup cycle, writes land at the access edge
    wire        acc      = psel & penable;
    wire        wr       = acc & pwrite;
    wire        rd_setup = psel & ~penable & ~pwrite;
    wire        hit_ctrl = svsi_hit(paddr, SVSI_OFF_ENABLE_CTRL);
    wire        hit_stat = svsi_hit(paddr, SVSI_OFF_STATUS);
    wire        hit_ie   = svsi_hit(paddr, SVSI_OFF_IRQ_ENABLE);
    wire        hit_if   = svsi_hit(paddr, SVSI_OFF_IRQ_FLAGS);
    wire        hit_rsv0 = svsi_hit(paddr, SVSI_OFF_RSVD_LO);
    wire        hit_rsv1 = svsi_hit(paddr, SVSI_OFF_RSVD_HI);
    wire        hit_mode = svsi_hit(paddr, SVSI_OFF_MODE);
    wire        hit_any  = hit_ctrl | hit_stat | hit_ie | hit_if | hit_rsv0 | hit_rsv1 | hit_mode;
    wire [7:0]  wbyte    = pwdata[7:0];
    wire        special  = mode_r[SVSI_SPECIAL_BIT];
    wire        cpu_stop = mode_r[SVSI_STOP_BIT];

    // Always zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit_any;
    assign prdata  = prdata_r;

    // Sense enables: either pin on means the comparator runs
    wire sese = ctrl_r[SVSI_SESE_BIT];
    wire suse = ctrl_r[SVSI_SUSE_BIT];
    wire cmp_on = sese | suse;

    // Control write: SESE set clears SUSE, SEAE set clears SUAE;
    // SUSE/SUAE can only be set while their sense-pin partner is clear
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr && hit_ctrl) begin
            ctrl_nxt = wbyte & SVSI_CTRL_MASK;
            if (wbyte[SVSI_SESE_BIT]) begin
                ctrl_nxt[SVSI_SUSE_BIT] = 1'b0;
            end
            if (wbyte[SVSI_SEAE_BIT]) begin
                ctrl_nxt[SVSI_SUAE_BIT] = 1'b0;
            end
        end
    end

    // Condition inputs gated by comparator enable, forced low when off
    wire low_gated  = low_cmp_in & cmp_on;
    wire high_gated = high_cmp_in & cmp_on;

    // Synchronise and edge-detect each condition
    logic low_condition;
    logic high_condition;
    logic low_chg;
    logic high_chg;

    svsi_cond_sync u_low_sync (
        .pclk         (pclk),
        .presetn      (presetn),
        .cond_in      (low_gated),
        .cond_sync    (low_condition),
        .cond_changed (low_chg)
    );

    svsi_cond_sync u_high_sync (
        .pclk         (pclk),
        .presetn      (presetn),
        .cond_in      (high_gated),
        .cond_sync    (high_condition),
        .cond_changed (high_chg)
    );

    // Flags: a change in the same cycle as a clearing write wins
    wire [1:0] flag_clr = (wr && hit_if) ? wbyte[1:0] : 2'h0;
    wire [1:0] flag_set = {high_chg, low_chg};
    assign irq_flag_nxt = (irq_flag_r & ~flag_clr) | flag_set;

    // Source request of one condition: its flag gated by its own enable
    function automatic logic svsi_src(input logic [1:0] flags, input logic [1:0] en, input int idx);
        return flags[idx] & en[idx];
    endfunction

    // Gated sources and merged request, held off while the CPU is stopped
    wire low_condition_irq  = svsi_src(irq_flag_r, irq_en_r, SVSI_LOW_BIT);
    wire high_condition_irq = svsi_src(irq_flag_r, irq_en_r, SVSI_HIGH_BIT);
    assign module_irq = (low_condition_irq | high_condition_irq) & ~cpu_stop;

    // Drive analog controls from the control register
    assign sense_pin_level_enable  = sese;
    assign supply_pin_level_enable = suse;
    assign sense_adc_connect       = ctrl_r[SVSI_SEAE_BIT];
    assign supply_adc_connect      = ctrl_r[SVSI_SUAE_BIT];
    assign low_threshold_select    = ctrl_r[SVSI_VLS_LSB +: 2];
    assign high_threshold_select   = ctrl_r[SVSI_VHS_BIT];

    // Read mux
    logic [7:0] rbyte;
    always_comb begin
        rbyte = 8'h00;
        if (hit_ctrl) begin
            rbyte = ctrl_r;
        end else if (hit_stat) begin
            rbyte = {6'h00, high_condition, low_condition};
        end else if (hit_ie) begin
            rbyte = {6'h00, irq_en_r};
        end else if (hit_if) begin
            rbyte = {6'h00, irq_flag_r};
        end else if (hit_rsv0) begin
            rbyte = rsvd_r[0];
        end else if (hit_rsv1) begin
            rbyte = rsvd_r[1];
        end else if (hit_mode) begin
            rbyte = {6'h00, mode_r};
        end
    end

    // Control and flag registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= SVSI_CTRL_RST;
            irq_flag_r <= SVSI_IF_RST;
        end else begin
            ctrl_r     <= ctrl_nxt;
            irq_flag_r <= irq_flag_nxt;
        end
    end

    // Enable register, writable in any mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= SVSI_IE_RST;
        end else if (wr && hit_ie) begin
            irq_en_r <= wbyte[1:0];
        end
    end

    // Mode register: special-mode and stop-mode indications from system
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= SVSI_MODE_RST;
        end else if (wr && hit_mode) begin
            mode_r <= wbyte[1:0];
        end
    end

    // Reserved test bytes: normal-mode writes dropped silently
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsvd_r[0] <= SVSI_RSVD_RST;
            rsvd_r[1] <= SVSI_RSVD_RST;
        end else if (wr && special && hit_rsv0) begin
            rsvd_r[0] <= wbyte;
        end else if (wr && special && hit_rsv1) begin
            rsvd_r[1] <= wbyte;
        end
    end

    // Read data captured at the setup edge, so it already stands when the access edge samples it;
    // no register here changes on a read, so fetching one cycle early loses nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_r <= {24'h00_0000, rbyte};
        end
    end

    // Assertions: each settled change sets its flag on the next edge
    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        low_chg |=> irq_flag_r[SVSI_LOW_BIT])
        else $error("low flag not set after change");

    high_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        high_chg |=> irq_flag_r[SVSI_HIGH_BIT])
        else $error("high flag not set after change");

    // A raw input change reaches its flag three edges later, through both stages
    sequence low_edge_s;
        $changed(low_gated);
    endsequence
    sequence low_flag_s;
        ##2 low_chg ##1 irq_flag_r[SVSI_LOW_BIT];
    endsequence
    low_path_a: assert property (@(posedge pclk) disable iff (!presetn)
        low_edge_s |-> low_flag_s)
        else $error("low change did not reach its flag");

    sequence high_edge_s;
        $changed(high_gated);
    endsequence
    sequence high_flag_s;
        ##2 high_chg ##1 irq_flag_r[SVSI_HIGH_BIT];
    endsequence
    high_path_a: assert property (@(posedge pclk) disable iff (!presetn)
        high_edge_s |-> high_flag_s)
        else $error("high change did not reach its flag");

    // Clearing: only a one clears, and nothing but a change or a clear moves a flag
    zero_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_if && !wbyte[0] && !low_chg) |=> irq_flag_r[0] == $past(irq_flag_r[0]))
        else $error("zero write altered low flag");

    one_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_if && wbyte[SVSI_LOW_BIT] && !low_chg) |=> !irq_flag_r[SVSI_LOW_BIT])
        else $error("one write did not clear low flag");

    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!(wr && hit_if) && flag_set == 2'h0) |=> irq_flag_r == $past(irq_flag_r))
        else $error("flag moved without change or clear");

    rd_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && !pwrite && hit_if) |-> prdata[1:0] == $past(irq_flag_r))
        else $error("flag read data wrong");

    // Stop mode masks the request and leaves the flags alone
    stop_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_stop |-> !module_irq)
        else $error("request delivered in stop mode");

    stop_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_mode && flag_set == 2'h0) |=> irq_flag_r == $past(irq_flag_r))
        else $error("mode change altered a flag");

    // Merged request follows the gated sources
    low_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_flag_r[0] && irq_en_r[0] && !cpu_stop) |-> module_irq)
        else $error("low request missing");

    high_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_flag_r[1] && irq_en_r[1] && !cpu_stop) |-> module_irq)
        else $error("high request missing");

    irq_merge_a: assert property (@(posedge pclk) disable iff (!presetn)
        module_irq |-> ((irq_flag_r & irq_en_r) != 2'h0) && !cpu_stop)
        else $error("request without enabled flag");

    irq_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((irq_flag_r & irq_en_r) == 2'h0) |-> !module_irq)
        else $error("request held after flags cleared");

    // Register access
    ie_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_ie) |=> irq_en_r == $past(wbyte[1:0]))
        else $error("enable write lost");

    rsvd_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && !special && hit_rsv0) |=> $stable(rsvd_r[0]))
        else $error("reserved write in normal mode");

    rsvd_hi_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && !special && hit_rsv1) |=> $stable(rsvd_r[1]))
        else $error("upper reserved write in normal mode");

    // Comparator off: conditions forced low, a held condition flags once more
    sequence cmp_off_s;
        !cmp_on [*3];
    endsequence
    forced_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_off_s |-> !low_condition && !high_condition)
        else $error("condition not forced low");

    sequence hi_drop_s;
        $fell(cmp_on) && high_condition;
    endsequence
    forced_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        hi_drop_s |-> ##[2:3] irq_flag_r[SVSI_HIGH_BIT])
        else $error("forced drop did not flag");

    // Pin and threshold selection
    sese_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_ctrl && wbyte[SVSI_SESE_BIT]) |=> !supply_pin_level_enable)
        else $error("supply sense not cleared");

    supply_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_ctrl && !wbyte[SVSI_SESE_BIT]) |=> supply_pin_level_enable == $past(wbyte[SVSI_SUSE_BIT]))
        else $error("supply sense write lost");

    seae_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_ctrl && wbyte[SVSI_SEAE_BIT]) |=> !supply_adc_connect)
        else $error("supply adc connect not cleared");

    thr_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_ctrl) |=> low_threshold_select == $past(wbyte[SVSI_VLS_LSB +: 2])
            && high_threshold_select == $past(wbyte[SVSI_VHS_BIT]))
        else $error("threshold select not taken");
endmodule
`default_nettype wire

// >>> verif/svsi_irq_sink.sv
// Interrupt controller stand-in that counts request edges
`timescale 1ns/100ps
`default_nettype none
module svsi_irq_sink (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Request from the block
    input  wire logic module_irq,
    output var  int   irq_edges
);
    logic irq_q;
    // A level request counts once per rising edge, so a held line is one interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q     <= 1'b0;
            irq_edges <= 0;
        end else begin
            irq_q <= module_irq;
            if (module_irq && !irq_q) irq_edges <= irq_edges + 1;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking testbench for the supply voltage sense interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import svsi_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        low_cmp_in = 0, high_cmp_in = 0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic        pready, pslverr, sense_en, supply_en, high_sel, module_irq, sense_adc, supply_adc;
    logic [1:0]  low_sel;
    logic [31:0] prdata;
    int          n_errors = 0, num_checks = 0, irq_edges, e0;

    // Design and interrupt controller model
    svsi_top u_svsi_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .low_cmp_in(low_cmp_in), .high_cmp_in(high_cmp_in), .sense_pin_level_enable(sense_en),
        .supply_pin_level_enable(supply_en), .supply_adc_connect(supply_adc), .sense_adc_connect(sense_adc),
        .low_threshold_select(low_sel), .high_threshold_select(high_sel), .module_irq(module_irq));
    svsi_irq_sink u_svsi_irq_sink (.pclk(pclk), .presetn(presetn), .module_irq(module_irq), .irq_edges(irq_edges));

    always #2.5 pclk = ~pclk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // APB transfer; response and read data are taken at the access edge where pready is high,
    // then one idle edge lets a write settle before the caller looks at the outputs
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask

    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task t_reset;
        rdchk(SVSI_OFF_IRQ_ENABLE, 32'h0);
        rdchk(SVSI_OFF_IRQ_FLAGS, 32'h0);
        apb(1'b0, 8'h30, 8'h00);
        chk(err, 1'b1);
        apb(1'b1, SVSI_OFF_IRQ_ENABLE, 8'hff);
        rdchk(SVSI_OFF_IRQ_ENABLE, 32'h3);
        apb(1'b1, SVSI_OFF_IRQ_ENABLE, 8'h00);
    endtask

    task t_low;
        apb(1'b1, SVSI_OFF_ENABLE_CTRL, 8'h01);
        apb(1'b1, SVSI_OFF_IRQ_ENABLE, 8'h01);
        low_cmp_in <= 1'b1;
        wt(8);
        rdchk(SVSI_OFF_STATUS, 32'h1);
        rdchk(SVSI_OFF_IRQ_FLAGS, 32'h1);
        chk(module_irq, 1'b1);
        apb(1'b1, SVSI_OFF_IRQ_FLAGS, 8'h00);
        rdchk(SVSI_OFF_IRQ_FLAGS, 32'h1);
        apb(1'b1, SVSI_OFF_IRQ_FLAGS, 8'h01);
        rdchk(SVSI_OFF_IRQ_FLAGS, 32'h0);
        chk(module_irq, 1'b0);
        low_cmp_in <= 1'b0;
        wt(8);
        rdchk(SVSI_OFF_IRQ_FLAGS, 32'h1);
        apb(1'b1, SVSI_OFF_IRQ_ENABLE, 8'h00);
        chk(module_irq, 1'b0);
        apb(1'b1, SVSI_OFF_IRQ_FLAGS, 8'h01);
    endtask

    task t_high;
        high_cmp_in <= 1'b1;
        wt(8);
        rdchk(SVSI_OFF_IRQ_FLAGS, 32'h2);
        chk(module_irq, 1'b0);
        apb(1'b1, SVSI_OFF_IRQ_ENABLE, 8'h02);
        chk(module_irq, 1'b1);
        apb(1'b1, SVSI_OFF_MODE, 8'h02);
        chk(module_irq, 1'b0);
        apb(1'b1, SVSI_OFF_MODE, 8'h00);
        rdchk(SVSI_OFF_IRQ_FLAGS, 32'h2);
        chk(module_irq, 1'b1);
    endtask

    // Sensing is switched off while the high condition holds and the enable is left set
    task t_disable;
        apb(1'b1, SVSI_OFF_IRQ_FLAGS, 8'h03);
        e0 = irq_edges;
        apb(1'b1, SVSI_OFF_ENABLE_CTRL, 8'h00);
        wt(8);
        rdchk(SVSI_OFF_STATUS, 32'h0);
        rdchk(SVSI_OFF_IRQ_FLAGS, 32'h2);
        chk(irq_edges - e0, 1);
        // Same drop again, with the enable cleared first as software should
        apb(1'b1, SVSI_OFF_ENABLE_CTRL, 8'h01);
        wt(8);
        apb(1'b1, SVSI_OFF_IRQ_ENABLE, 8'h00);
        apb(1'b1, SVSI_OFF_IRQ_FLAGS, 8'h03);
        e0 = irq_edges;
        apb(1'b1, SVSI_OFF_ENABLE_CTRL, 8'h00);
        wt(8);
        chk(irq_edges - e0, 0);
        chk(module_irq, 1'b0);
        high_cmp_in <= 1'b0;
        apb(1'b1, SVSI_OFF_IRQ_FLAGS, 8'h03);
    endtask

    task t_ctrl;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, SVSI_OFF_ENABLE_CTRL, {1'b0, i[0], i[1:0], 4'h4});
            chk(low_sel, i[1:0]);
            chk(high_sel, i[0]);
            chk(supply_en, 1'b1);
        end
        apb(1'b1, SVSI_OFF_ENABLE_CTRL, 8'h05);
        chk(supply_en, 1'b0);
        chk(sense_en, 1'b1);
        apb(1'b1, SVSI_OFF_ENABLE_CTRL, 8'h08);
        chk(supply_adc, 1'b1);
        apb(1'b1, SVSI_OFF_ENABLE_CTRL, 8'h0a);
        chk(supply_adc, 1'b0);
        chk(sense_adc, 1'b1);
        apb(1'b1, SVSI_OFF_ENABLE_CTRL, 8'h00);
    endtask

    task t_rsvd;
        apb(1'b1, SVSI_OFF_RSVD_LO, 8'h5a);
        rdchk(SVSI_OFF_RSVD_LO, 32'h0);
        apb(1'b1, SVSI_OFF_RSVD_HI, 8'ha5);
        rdchk(SVSI_OFF_RSVD_HI, 32'h0);
        apb(1'b1, SVSI_OFF_MODE, 8'h01);
        apb(1'b1, SVSI_OFF_RSVD_LO, 8'h5a);
        rdchk(SVSI_OFF_RSVD_LO, 32'h5a);
        apb(1'b1, SVSI_OFF_RSVD_HI, 8'ha5);
        rdchk(SVSI_OFF_RSVD_HI, 32'ha5);
        apb(1'b1, SVSI_OFF_RSVD_LO, 8'h00);
        apb(1'b1, SVSI_OFF_RSVD_HI, 8'h00);
        apb(1'b1, SVSI_OFF_MODE, 8'h00);
    endtask

    task test_done;
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        wt(3);
        presetn <= 1'b1;
        t_reset;
        t_low;
        t_high;
        t_disable;
        t_ctrl;
        t_rsvd;
        test_done;
    end

    // Watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        #100000;
        n_errors++;
        test_done;
    end
endmodule
`default_nettype wire
